//--- verilog/etpwm_map.svh
`ifndef ETPWM_MAP_SVH
`define ETPWM_MAP_SVH

// register byte addresses
`define ETPWM_ADDR_CTRL_A 8'h24
`define ETPWM_ADDR_CTRL_B 8'h25
`define ETPWM_ADDR_COUNT 8'h26
`define ETPWM_ADDR_CMP_A 8'h27
`define ETPWM_ADDR_CMP_B 8'h28
`define ETPWM_ADDR_FLAGS 8'h29
`define ETPWM_ADDR_PIN 8'h2a

// reset values
`define ETPWM_RST_BYTE 8'h00

// clock and mode control fields
`define ETPWM_CB_CS_MSB 2
`define ETPWM_CB_CS_LSB 0
`define ETPWM_CB_MODE_HI 3
`define ETPWM_CB_WMASK 8'h0f

// flag register fields
`define ETPWM_FL_OVF 0
`define ETPWM_FL_CMP_A 1
`define ETPWM_FL_CMP_B 2

// pin control fields
`define ETPWM_PIN_DIR_A 0
`define ETPWM_PIN_DIR_B 1
`define ETPWM_PIN_OC_A 2
`define ETPWM_PIN_OC_B 3
`define ETPWM_PIN_DAT_A 4
`define ETPWM_PIN_DAT_B 5
`define ETPWM_PIN_WMASK 8'h33

// counter limits
`define ETPWM_BOTTOM 8'h00
`define ETPWM_MAX 8'hff
`define ETPWM_ONE 8'h01

// waveform mode codes
`define ETPWM_WGM_PC_FIX 3'h1
`define ETPWM_WGM_FAST_FIX 3'h3
`define ETPWM_WGM_PC_VAR 3'h5
`define ETPWM_WGM_FAST_VAR 3'h7

// output action codes
`define ETPWM_ACT_OFF 2'h0
`define ETPWM_ACT_TOGGLE 2'h1
`define ETPWM_ACT_NONINV 2'h2
`define ETPWM_ACT_INV 2'h3

// prescaler clock selects and divide masks
`define ETPWM_CS_DIV1 3'h1
`define ETPWM_CS_DIV8 3'h2
`define ETPWM_CS_DIV64 3'h3
`define ETPWM_CS_DIV256 3'h4
`define ETPWM_CS_DIV1024 3'h5
`define ETPWM_MASK_DIV1 10'h000
`define ETPWM_MASK_DIV8 10'h007
`define ETPWM_MASK_DIV64 10'h03f
`define ETPWM_MASK_DIV256 10'h0ff
`define ETPWM_MASK_DIV1024 10'h3ff

`endif

//--- verilog/etpwm_pkg.sv
`default_nettype none
package etpwm_pkg;

    // output and mode control layout
    typedef struct packed {
        logic [1:0] output_action_a;
        logic [1:0] output_action_b;
        logic [1:0] reserved;
        logic waveform_mode_bit1;
        logic waveform_mode_bit0;
    } etpwm_ctrl_a_t;

    // counting direction
    typedef enum logic [1:0] {
        ETPWM_DIR_UP = 2'b01,
        ETPWM_DIR_DOWN = 2'b10
    } etpwm_dir_t;

    // one pin: driven level and enable
    typedef struct packed {
        logic value;
        logic oe;
    } etpwm_pin_t;

endpackage

`default_nettype wire

//--- verilog/etpwm_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "etpwm_map.svh"

module etpwm_prescaler (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // clock select
    input wire logic [2:0] clock_select_i,
    // prescaled timer tick
    output logic timer_tick_o
);

    logic [9:0] div_cnt_reg;
    logic [9:0] mask;
    logic run;

    // divide mask per clock select, other codes stop the timer
    always_comb begin
        run = 1'b1;
        mask = `ETPWM_MASK_DIV1;
        unique case (clock_select_i)
            `ETPWM_CS_DIV1: mask = `ETPWM_MASK_DIV1;
            `ETPWM_CS_DIV8: mask = `ETPWM_MASK_DIV8;
            `ETPWM_CS_DIV64: mask = `ETPWM_MASK_DIV64;
            `ETPWM_CS_DIV256: mask = `ETPWM_MASK_DIV256;
            `ETPWM_CS_DIV1024: mask = `ETPWM_MASK_DIV1024;
            default: run = 1'b0;
        endcase
    end

    // free running divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_reg <= 10'h000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 10'h001;
        end
    end

    // tick once every divide factor cycles
    assign timer_tick_o = run && ((div_cnt_reg & mask) == mask);

endmodule

`default_nettype wire

//--- verilog/etpwm_top.sv
// How it works
// - modes 3 and 7 run single slope
// - fast top: 0xff, or compare a
// - non-inverting clears on match, sets at wrap
// - action two non-inverted, three inverted
// - count up to top, then bottom
// - fast overflow flag set at top
// - action one toggles a, only high bit
// - pin shows output only when direction out
// - fast period 256 ticks at 0xff
// - bottom gives spike, max gives constant
// - compare double buffered, toggle gives 50%
// - modes 1 and 5 run dual slope
// - phase top: 0xff, or compare a
// - up match clears, down match sets
// - reverse at top, top held one tick
// - phase overflow flag set at bottom
// - phase period 510 ticks at 0xff
// - bottom continuously low, max continuously high
// - forced transition keeps symmetry about bottom
// - synchronous, counts only on timer tick
// - control a layout, reserved zero, reset 0
// - mode high bit in control b
// - action zero disconnects, no match action
`timescale 1ns/10ps
`default_nettype none
`include "etpwm_map.svh"

module etpwm_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    // compare output pins
    output var etpwm_pkg::etpwm_pin_t pin_a_o,
    output var etpwm_pkg::etpwm_pin_t pin_b_o
);

    // software registers
    etpwm_pkg::etpwm_ctrl_a_t timer_output_and_mode_control_reg;
    logic [7:0] timer_clock_and_mode_control_reg;
    logic [7:0] compare_value_a_buf_reg;
    logic [7:0] compare_value_b_buf_reg;
    logic [7:0] pin_ctrl_reg;
    logic [2:0] flags_reg;
    logic [7:0] rdata_reg;

    // timer state
    logic [7:0] count_value_reg;
    logic [7:0] count_value_next;
    etpwm_pkg::etpwm_dir_t dir_reg;
    etpwm_pkg::etpwm_dir_t dir_next;
    logic [7:0] compare_value_a_reg;
    logic [7:0] compare_value_b_reg;
    logic block_reg;
    logic compare_output_a_reg;
    logic compare_output_a_next;
    logic compare_output_b_reg;
    logic compare_output_b_next;
    etpwm_pkg::etpwm_pin_t pin_a_reg;
    etpwm_pkg::etpwm_pin_t pin_b_reg;

    // decoded controls
    logic timer_tick;
    logic [2:0] waveform_mode_select;
    logic waveform_mode_high_bit;
    logic [1:0] output_action_a;
    logic [1:0] output_action_b;
    logic is_fast;
    logic is_phase;
    logic [7:0] top;
    logic at_top;
    logic at_bottom;
    logic reach_top;
    logic wrap;
    logic overflow_evt;
    logic match_a;
    logic match_b;
    logic reload;
    logic connect_a;
    logic connect_b;
    logic [2:0] flag_clear;

    // write strobe hitting one register
    function automatic logic wr_hit(input logic we, input logic [7:0] addr, input logic [7:0] target);
        wr_hit = we && (addr == target);
    endfunction

    // next compare output level for one channel
    function automatic logic next_level(
        input logic cur,
        input logic [1:0] act,
        input logic toggle_ok,
        input logic fast,
        input logic phase,
        input logic up,
        input logic match,
        input logic cmp_is_top,
        input logic wrapped,
        input logic bottom,
        input logic cmp_zero
    );
        logic inv;
        inv = (act == `ETPWM_ACT_INV);
        next_level = cur;
        if (act == `ETPWM_ACT_TOGGLE) begin
            if (toggle_ok && match && (fast || phase)) begin
                next_level = ~cur;
            end
        end else if (act[1] && fast) begin
            if (wrapped) begin
                next_level = ~inv;
            end else if (match && !cmp_is_top) begin
                next_level = inv;
            end
        end else if (act[1] && phase) begin
            if (bottom) begin
                next_level = cmp_zero ? inv : ~inv;
            end else if (match && !cmp_is_top) begin
                next_level = up ? inv : ~inv;
            end
        end
    endfunction

    // prescaled timer tick
    etpwm_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clock_select_i(timer_clock_and_mode_control_reg[`ETPWM_CB_CS_MSB:`ETPWM_CB_CS_LSB]),
        .timer_tick_o(timer_tick)
    );

    // mode decode
    always_comb begin
        output_action_a = timer_output_and_mode_control_reg.output_action_a;
        output_action_b = timer_output_and_mode_control_reg.output_action_b;
        waveform_mode_high_bit = timer_clock_and_mode_control_reg[`ETPWM_CB_MODE_HI];
        waveform_mode_select = {waveform_mode_high_bit,
                                timer_output_and_mode_control_reg.waveform_mode_bit1,
                                timer_output_and_mode_control_reg.waveform_mode_bit0};
        is_fast = (waveform_mode_select == `ETPWM_WGM_FAST_FIX) || (waveform_mode_select == `ETPWM_WGM_FAST_VAR);
        is_phase = (waveform_mode_select == `ETPWM_WGM_PC_FIX) || (waveform_mode_select == `ETPWM_WGM_PC_VAR);
        top = (waveform_mode_high_bit && (is_fast || is_phase)) ? compare_value_a_reg : `ETPWM_MAX;
    end

    // counter sequencing
    always_comb begin
        at_top = (count_value_reg == top);
        at_bottom = (count_value_reg == `ETPWM_BOTTOM);
        count_value_next = count_value_reg + `ETPWM_ONE;
        dir_next = dir_reg;
        wrap = 1'b0;
        reach_top = 1'b0;
        overflow_evt = 1'b0;
        if (is_fast) begin
            wrap = at_top;
            reach_top = at_top;
            if (at_top) begin
                count_value_next = `ETPWM_BOTTOM;
            end
            overflow_evt = at_top;
        end else if (is_phase) begin
            if (dir_reg == etpwm_pkg::ETPWM_DIR_UP) begin
                reach_top = (count_value_reg >= top);
                if (reach_top) begin
                    dir_next = etpwm_pkg::ETPWM_DIR_DOWN;
                    count_value_next = (top == `ETPWM_BOTTOM) ? `ETPWM_BOTTOM : count_value_reg - `ETPWM_ONE;
                end
            end else begin
                if (at_bottom) begin
                    dir_next = etpwm_pkg::ETPWM_DIR_UP;
                    count_value_next = (top == `ETPWM_BOTTOM) ? `ETPWM_BOTTOM : `ETPWM_ONE;
                end else begin
                    count_value_next = count_value_reg - `ETPWM_ONE;
                end
            end
            overflow_evt = at_bottom && (dir_reg == etpwm_pkg::ETPWM_DIR_DOWN);
        end else begin
            dir_next = etpwm_pkg::ETPWM_DIR_UP;
            overflow_evt = (count_value_reg == `ETPWM_MAX);
        end
    end

    // compare matches and output levels
    always_comb begin
        match_a = (count_value_reg == compare_value_a_reg) && !block_reg;
        match_b = (count_value_reg == compare_value_b_reg) && !block_reg;
        reload = !(is_fast || is_phase) || (timer_tick && reach_top);
        compare_output_a_next = next_level(compare_output_a_reg, output_action_a, waveform_mode_high_bit,
                                           is_fast, is_phase, dir_reg == etpwm_pkg::ETPWM_DIR_UP, match_a,
                                           compare_value_a_reg == top, wrap, is_phase && at_bottom,
                                           compare_value_a_reg == `ETPWM_BOTTOM);
        compare_output_b_next = next_level(compare_output_b_reg, output_action_b, 1'b0,
                                           is_fast, is_phase, dir_reg == etpwm_pkg::ETPWM_DIR_UP, match_b,
                                           compare_value_b_reg == top, wrap, is_phase && at_bottom,
                                           compare_value_b_reg == `ETPWM_BOTTOM);
        // pin override only for a live action
        connect_a = output_action_a[1] || (output_action_a == `ETPWM_ACT_TOGGLE &&
                    (waveform_mode_high_bit || !(is_fast || is_phase)));
        connect_b = output_action_b[1] || (output_action_b == `ETPWM_ACT_TOGGLE && !(is_fast || is_phase));
        flag_clear = wr_hit(we_i, addr_i, `ETPWM_ADDR_FLAGS) ? wdata_i[2:0] : 3'h0;
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_output_and_mode_control_reg <= `ETPWM_RST_BYTE;
            timer_clock_and_mode_control_reg <= `ETPWM_RST_BYTE;
            pin_ctrl_reg <= `ETPWM_RST_BYTE;
        end else begin
            if (wr_hit(we_i, addr_i, `ETPWM_ADDR_CTRL_A)) begin
                timer_output_and_mode_control_reg <= {wdata_i[7:4], 2'h0, wdata_i[1:0]};
            end
            if (wr_hit(we_i, addr_i, `ETPWM_ADDR_CTRL_B)) begin
                timer_clock_and_mode_control_reg <= wdata_i & `ETPWM_CB_WMASK;
            end
            if (wr_hit(we_i, addr_i, `ETPWM_ADDR_PIN)) begin
                pin_ctrl_reg <= wdata_i & `ETPWM_PIN_WMASK;
            end
        end
    end

    // compare buffers written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_value_a_buf_reg <= `ETPWM_RST_BYTE;
            compare_value_b_buf_reg <= `ETPWM_RST_BYTE;
        end else begin
            if (wr_hit(we_i, addr_i, `ETPWM_ADDR_CMP_A)) begin
                compare_value_a_buf_reg <= wdata_i;
            end
            if (wr_hit(we_i, addr_i, `ETPWM_ADDR_CMP_B)) begin
                compare_value_b_buf_reg <= wdata_i;
            end
        end
    end

    // active compare values, double buffered in pwm modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_value_a_reg <= `ETPWM_RST_BYTE;
            compare_value_b_reg <= `ETPWM_RST_BYTE;
        end else if (reload) begin
            compare_value_a_reg <= compare_value_a_buf_reg;
            compare_value_b_reg <= compare_value_b_buf_reg;
        end
    end

    // counter and direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_value_reg <= `ETPWM_RST_BYTE;
            dir_reg <= etpwm_pkg::ETPWM_DIR_UP;
            block_reg <= 1'b0;
        end else if (wr_hit(we_i, addr_i, `ETPWM_ADDR_COUNT)) begin
            // a count write masks matches for one tick
            count_value_reg <= wdata_i;
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            count_value_reg <= count_value_next;
            dir_reg <= dir_next;
            block_reg <= 1'b0;
        end
    end

    // compare output registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_output_a_reg <= 1'b0;
            compare_output_b_reg <= 1'b0;
        end else if (timer_tick) begin
            compare_output_a_reg <= compare_output_a_next;
            compare_output_b_reg <= compare_output_b_next;
        end
    end

    // sticky flags, write one to clear, hardware set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= 3'h0;
        end else begin
            flags_reg[`ETPWM_FL_OVF] <= (flags_reg[`ETPWM_FL_OVF] && !flag_clear[`ETPWM_FL_OVF]) ||
                                        (timer_tick && overflow_evt);
            flags_reg[`ETPWM_FL_CMP_A] <= (flags_reg[`ETPWM_FL_CMP_A] && !flag_clear[`ETPWM_FL_CMP_A]) ||
                                          (timer_tick && match_a);
            flags_reg[`ETPWM_FL_CMP_B] <= (flags_reg[`ETPWM_FL_CMP_B] && !flag_clear[`ETPWM_FL_CMP_B]) ||
                                          (timer_tick && match_b);
        end
    end

    // pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_a_reg <= 2'h0;
            pin_b_reg <= 2'h0;
        end else begin
            pin_a_reg.oe <= pin_ctrl_reg[`ETPWM_PIN_DIR_A];
            pin_a_reg.value <= connect_a ? compare_output_a_reg : pin_ctrl_reg[`ETPWM_PIN_DAT_A];
            pin_b_reg.oe <= pin_ctrl_reg[`ETPWM_PIN_DIR_B];
            pin_b_reg.value <= connect_b ? compare_output_b_reg : pin_ctrl_reg[`ETPWM_PIN_DAT_B];
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= `ETPWM_RST_BYTE;
        end else if (re_i) begin
            unique case (addr_i)
                `ETPWM_ADDR_CTRL_A: rdata_reg <= timer_output_and_mode_control_reg;
                `ETPWM_ADDR_CTRL_B: rdata_reg <= timer_clock_and_mode_control_reg;
                `ETPWM_ADDR_COUNT: rdata_reg <= count_value_reg;
                `ETPWM_ADDR_CMP_A: rdata_reg <= compare_value_a_buf_reg;
                `ETPWM_ADDR_CMP_B: rdata_reg <= compare_value_b_buf_reg;
                `ETPWM_ADDR_FLAGS: rdata_reg <= {5'h00, flags_reg};
                `ETPWM_ADDR_PIN: rdata_reg <= pin_ctrl_reg | {4'h0, compare_output_b_reg, compare_output_a_reg, 2'h0};
                default: rdata_reg <= `ETPWM_RST_BYTE;
            endcase
        end else begin
            rdata_reg <= `ETPWM_RST_BYTE;
        end
    end

    assign rdata_o = rdata_reg;
    assign pin_a_o = pin_a_reg;
    assign pin_b_o = pin_b_reg;

endmodule

`default_nettype wire

//--- tb/ebtpm_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "etpwm_map.svh"

module ebtpm_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [7:0] rdata_o,
    // compare output pins
    input wire etpwm_pkg::etpwm_pin_t pin_a_o,
    input wire etpwm_pkg::etpwm_pin_t pin_b_o
);
    logic [7:0] ctl_a_reg;
    logic [7:0] ctl_b_reg;
    logic [7:0] cmp_a_reg;
    logic [7:0] pin_reg;
    logic [10:0] quiet_reg;
    logic [2:0] mode;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // shadow of what software last wrote
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_a_reg <= 8'h00;
            ctl_b_reg <= 8'h00;
            cmp_a_reg <= 8'h00;
            pin_reg <= 8'h00;
        end else if (we_i) begin
            if (addr_i == `ETPWM_ADDR_CTRL_A) ctl_a_reg <= wdata_i & 8'hf3;
            if (addr_i == `ETPWM_ADDR_CTRL_B) ctl_b_reg <= wdata_i & 8'h0f;
            if (addr_i == `ETPWM_ADDR_CMP_A) cmp_a_reg <= wdata_i;
            if (addr_i == `ETPWM_ADDR_PIN) pin_reg <= wdata_i & 8'h33;
        end
    end

    // cycles since the last write, saturating, so steady states can be judged
    always_ff @(posedge clk_i) begin
        if (rst_i || we_i) begin
            quiet_reg <= 11'h000;
        end else if (quiet_reg != 11'h7ff) begin
            quiet_reg <= quiet_reg + 11'h001;
        end
    end

    // full waveform mode from both control registers
    assign mode = {ctl_b_reg[3], ctl_a_reg[1:0]};

    a_rdata_idle_zero: assert property (!re_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read_zero: assert property (re_i && (addr_i < 8'h24 || addr_i > 8'h2a) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_a_readback: assert property (re_i && addr_i == `ETPWM_ADDR_CTRL_A |=> rdata_o == $past(ctl_a_reg))
        else $error("control a readback wrong");
    a_ctrl_b_readback: assert property (re_i && addr_i == `ETPWM_ADDR_CTRL_B |=> rdata_o == $past(ctl_b_reg))
        else $error("control b readback wrong");
    a_pin_reg_readback: assert property (re_i && addr_i == `ETPWM_ADDR_PIN |=> (rdata_o & 8'h33) == $past(pin_reg))
        else $error("pin register readback wrong");
    a_pin_enable_dir: assert property (quiet_reg > 11'h003 |-> pin_a_o.oe == pin_reg[0] && pin_b_o.oe == pin_reg[1])
        else $error("pin enable differs from direction");
    a_port_data_a: assert property (quiet_reg > 11'h003 && (ctl_a_reg[7:6] == 2'h0 ||
        (ctl_a_reg[7:6] == 2'h1 && ctl_a_reg[0] && !ctl_b_reg[3])) |-> pin_a_o.value == pin_reg[4])
        else $error("pin a not port data while disconnected");
    // channel b has no toggle in pwm
    a_port_data_b: assert property (quiet_reg > 11'h003 && (ctl_a_reg[5:4] == 2'h0 ||
        (ctl_a_reg[5:4] == 2'h1 && ctl_a_reg[0])) |-> pin_b_o.value == pin_reg[5])
        else $error("pin b not port data while disconnected");
    // fast compare at max is constant
    a_fast_max_level: assert property (quiet_reg > 11'h258 && mode == `ETPWM_WGM_FAST_FIX &&
        ctl_b_reg[2:0] == 3'h1 && cmp_a_reg == 8'hff && ctl_a_reg[7] |-> pin_a_o.value == !ctl_a_reg[6])
        else $error("fast pwm at max not constant");
    a_phase_extreme: assert property (quiet_reg > 11'h4b0 && mode == `ETPWM_WGM_PC_FIX &&
        ctl_b_reg[2:0] == 3'h1 && ctl_a_reg[7] && (cmp_a_reg == 8'h00 || cmp_a_reg == 8'hff)
        |-> pin_a_o.value == ((cmp_a_reg == 8'hff) ^ ctl_a_reg[6]))
        else $error("phase pwm extreme not constant");

    // main scenarios reached
    c_read_ctrl: cover property (re_i && addr_i == `ETPWM_ADDR_CTRL_A);
    c_fast_var: cover property (quiet_reg > 11'h258 && mode == `ETPWM_WGM_FAST_VAR && $rose(pin_a_o.value));
    c_phase_var: cover property (quiet_reg > 11'h258 && mode == `ETPWM_WGM_PC_VAR && $rose(pin_b_o.value));
endmodule

bind etpwm_top ebtpm_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .pin_a_o(pin_a_o), .pin_b_o(pin_b_o)
);
`default_nettype wire

//--- tb/eight_bit_timer_pwm_modes_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "etpwm_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end

module eight_bit_timer_pwm_modes_tb;
    typedef struct {logic [15:0] e0; logic [15:0] e1; logic [15:0] e2; logic [15:0] len;} ebtpm_note_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [7:0] rdata_o;
    etpwm_pkg::etpwm_pin_t pin_a_o;
    etpwm_pkg::etpwm_pin_t pin_b_o;
    logic pin_go = 1'b0;
    logic meas_go = 1'b0;
    logic rd_seen = 1'b0;
    logic prev_a = 1'b0;
    int err_count = 0;
    int compares = 0;
    int left = 0;
    int hi_a = 0;
    int hi_b = 0;
    int rise_a = 0;
    ebtpm_note_t notes[$];
    ebtpm_note_t cur;
    // per case: mode, actions, compare picks (-1 random, -2 top or below top)
    int md_t[9] = '{3, 3, 3, 1, 1, 1, 7, 5, 3};
    int aa_t[9] = '{2, 2, 3, 2, 2, 3, 1, 1, 1};
    int ab_t[9] = '{3, 2, 3, 3, 3, 2, 2, 2, 1};
    int ca_t[9] = '{-1, 0, 255, -1, 0, 255, -2, -2, -1};
    int cb_t[9] = '{-1, 255, 0, -1, 255, 0, -2, -2, -1};

    etpwm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
        .re_i(re_i), .rdata_o(rdata_o), .pin_a_o(pin_a_o), .pin_b_o(pin_b_o));

    // free running clock
    always #5 clk_i = ~clk_i;

    // takes the oldest note whenever a result shows and compares it
    always @(posedge clk_i) begin
        if (rd_seen || pin_go || meas_go) cur = notes.pop_front();
        if (rd_seen) `CHK({8'h00, rdata_o} & cur.e1, cur.e0)
        if (pin_go) `CHK({12'h000, pin_b_o, pin_a_o}, cur.e0)
        if (meas_go) begin
            left = cur.len;
            hi_a = 0;
            hi_b = 0;
            rise_a = 0;
            prev_a = pin_a_o.value;
        end else if (left > 0) begin
            hi_a += pin_a_o.value;
            hi_b += pin_b_o.value;
            rise_a += (pin_a_o.value && !prev_a);
            prev_a = pin_a_o.value;
            left--;
            if (left == 0) begin
                `CHK(16'(hi_a), cur.e0)
                `CHK(16'(rise_a), cur.e1)
                `CHK(16'(hi_b), cur.e2)
            end
        end
        rd_seen <= re_i;
    end

    task automatic final_report;
        $display("compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back('{{8'h00, e & m}, {8'h00, m}, 16'h0000, 16'h0000});
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
    endtask

    task automatic pchk(input logic [3:0] e);
        notes.push_back('{{12'h000, e}, 16'h0000, 16'h0000, 16'h0000});
        @(posedge clk_i);
        pin_go <= 1'b1;
        @(posedge clk_i);
        pin_go <= 1'b0;
    endtask

    // high cycles of a and b and rising edges of a over len cycles
    task automatic meas(input int len, input int ha, input int ra, input int hb);
        int i;
        notes.push_back('{16'(ha), 16'(ra), 16'(hb), 16'(len)});
        @(posedge clk_i);
        meas_go <= 1'b1;
        @(posedge clk_i);
        meas_go <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < len + 8 && left != 0; i++) @(posedge clk_i);
        if (left != 0) begin
            err_count++;
            $display("wrong value at %0t: measurement stuck", $time);
            final_report();
        end
    endtask

    // high ticks per period; a disconnected pin shows port data one
    function automatic int hper(input int c, input int act, input bit fast, input int p, input int t, input bit con);
        int b;
        b = (c >= t) ? p : (fast ? c + 1 : 2 * c);
        if (!con) return p;
        return (act == 3) ? p - b : b;
    endfunction

    initial begin
        int k, ca, cb, t, p, w, ha, ra, hb;
        logic [7:0] v;
        bit fast;
        void'($urandom(23967));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 8'h22; k < 8'h2c; k++) rd(8'(k), 8'h00, 8'hff); // all zero
        for (k = 0; k < 4; k++) begin
            v = 8'($urandom);
            wr(`ETPWM_ADDR_CTRL_A, v);
            rd(`ETPWM_ADDR_CTRL_A, v & 8'hf3, 8'hff); // reserved bits zero
            wr(`ETPWM_ADDR_CTRL_B, v & 8'hf8);
            rd(`ETPWM_ADDR_CTRL_B, v & 8'h08, 8'hff); // high mode bit
            wr(`ETPWM_ADDR_COUNT, v);
            rd(`ETPWM_ADDR_COUNT, v, 8'hff); // no tick, no count
            v = 8'($urandom) & 8'h33;
            wr(`ETPWM_ADDR_CTRL_A, 8'h00);
            wr(`ETPWM_ADDR_PIN, v);
            pchk({v[5], v[1], v[4], v[0]}); // port pins
        end
        // waveform cases at divide by one
        for (k = 0; k < 9; k++) begin
            t = 16 + $urandom % 85;
            ca = ca_t[k] == -1 ? $urandom % 256 : (ca_t[k] == -2 ? t : ca_t[k]);
            cb = cb_t[k] == -1 ? $urandom % 256 : (cb_t[k] == -2 ? $urandom % t : cb_t[k]);
            fast = md_t[k][1];
            t = md_t[k][2] ? ca : 255;
            p = fast ? t + 1 : 2 * t;
            w = (aa_t[k] == 1 && md_t[k][2]) ? 4 * p : 2 * p;
            ha = (w == 4 * p) ? 2 * p : 2 * hper(ca, aa_t[k], fast, p, t, aa_t[k] > 1);
            ra = (w == 4 * p) ? 2 : ((ha == 0 || ha == w) ? 0 : 2);
            hb = (w / p) * hper(cb, ab_t[k], fast, p, t, ab_t[k] > 1);
            wr(`ETPWM_ADDR_CTRL_B, 8'h00);
            wr(`ETPWM_ADDR_PIN, 8'h33);
            wr(`ETPWM_ADDR_CMP_A, 8'(ca));
            wr(`ETPWM_ADDR_CMP_B, 8'(cb));
            wr(`ETPWM_ADDR_CTRL_A, {2'(aa_t[k]), 2'(ab_t[k]), 2'b00, md_t[k][1:0]});
            wr(`ETPWM_ADDR_CTRL_B, {4'h0, md_t[k][2], 3'h1});
            repeat (1100) @(posedge clk_i);
            meas(w, ha, ra, hb); // duty and period
            rd(`ETPWM_ADDR_FLAGS, 8'h01, 8'h01); // overflow seen
            wr(`ETPWM_ADDR_CTRL_B, 8'h00);
            wr(`ETPWM_ADDR_FLAGS, 8'h07);
            rd(`ETPWM_ADDR_FLAGS, 8'h00, 8'h07); // flag cleared
        end
        repeat (4) @(posedge clk_i);
        final_report();
    end
endmodule
`default_nettype wire
